/* File: hdl/nib_buf.sv */
`default_nettype none
module nib_buf (
  input wire logic clk_sys,
  input wire logic rst,
  nib_buf_if.store bif
);
  import phy_pkg::*;

  typedef struct packed {
    logic [BUF_DEPTH-1:0][NIB_W-1:0] mem;
    logic wp;
    logic rp;
    logic [BUF_CNT_W-1:0] cnt;
  } buf_state_t;

  buf_state_t r;
  buf_state_t n;
  logic push;
  logic pop;

  // ----------------------------------------------------------------
  // Two-entry store; read data come straight from the entry registers.
  // ----------------------------------------------------------------
  assign bif.wready = (r.cnt != BUF_CNT_W'(BUF_DEPTH));
  assign bif.rvalid = (r.cnt != '0);
  assign bif.rdata = r.mem[r.rp];

  always_comb begin
    n = r;
    push = bif.wvalid & bif.wready;
    pop = bif.rvalid & bif.rready;
    if (push) begin
      n.mem[r.wp] = bif.wdata;
      n.wp = ~r.wp;
    end
    if (pop) begin
      n.rp = ~r.rp;
    end
    if (push & ~pop) begin
      n.cnt = r.cnt + 1'b1;
    end else if (pop & ~push) begin
      n.cnt = r.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

endmodule
`default_nettype wire

/* File: hdl/phy_mii_timing.sv */
`default_nettype none
module phy_mii_timing #(
  parameter int LINK_LOSS_CYC = phy_pkg::LINK_LOSS_CYC_DFLT,
  parameter int LINK_MIN_RX_CYC = phy_pkg::LINK_MIN_RX_CYC_DFLT,
  parameter int LINK_TX_PERIOD_CYC = phy_pkg::LINK_TX_PERIOD_CYC_DFLT
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic mii_clk,
  input wire logic tx_en,
  input wire logic [phy_pkg::NIB_W-1:0] txd,
  input wire logic speed_10,
  input wire logic link_pulse_in,
  input wire logic line_rx_j,
  input wire logic line_rx_t,
  input wire logic line_rx_vld,
  input wire logic [phy_pkg::NIB_W-1:0] line_rx_nib,
  input wire logic line_tx_rdy,
  output logic crs,
  output logic col,
  output logic rx_dv,
  output logic [phy_pkg::NIB_W-1:0] rxd,
  output logic line_output_pair_vld,
  output logic [phy_pkg::NIB_W-1:0] line_output_pair,
  output logic tx_stall,
  output logic link_up,
  output logic link_pulse_out
);
  import phy_pkg::*;

  typedef struct packed {
    logic [SY_W-1:0] sync1;
    logic [SY_W-1:0] sync2;
    logic mclk_d;
    logic lp_d;
    logic [D_NUM-1:0][DLY_W-1:0] dly;
    logic tx_act;
    logic crs_tx;
    logic crs_rx;
    logic crs;
    logic col;
    logic rx_dv;
    logic [NIB_W-1:0] rxd;
    logic ltx_vld;
    logic [NIB_W-1:0] ltx_nib;
    logic stall;
    link_state_t lstate;
    logic link_up;
    logic [TMR_W-1:0] since;
    logic [TMR_W-1:0] tlt;
    logic [DLY_W-1:0] lpw;
    logic lp_out;
  } phy_state_t;

  phy_state_t r;
  phy_state_t n;
  logic [D_NUM-1:0] fire;
  logic mclk_rise;
  logic tx_en_s;
  logic spd10_s;
  logic lp_s;
  logic lp_rise;

  nib_buf_if bif ();

  nib_buf u_buf (
    .clk_sys(clk_sys),
    .rst(rst),
    .bif(bif.store)
  );

  assign crs = r.crs;
  assign col = r.col;
  assign rx_dv = r.rx_dv;
  assign rxd = r.rxd;
  assign line_output_pair_vld = r.ltx_vld;
  assign line_output_pair = r.ltx_nib;
  assign tx_stall = r.stall;
  assign link_up = r.link_up;
  assign link_pulse_out = r.lp_out;

  always_comb begin
    n = r;
    // ----------------------------------------------------------------
    // Synchronisers and link clock edge detection
    // ----------------------------------------------------------------
    n.sync1 = {speed_10, link_pulse_in, tx_en, txd, mii_clk};
    n.sync2 = r.sync1;
    n.mclk_d = r.sync2[SY_MCLK];
    n.lp_d = r.sync2[SY_LP];
    mclk_rise = r.sync2[SY_MCLK] & ~r.mclk_d;
    tx_en_s = r.sync2[SY_TXEN];
    spd10_s = r.sync2[SY_SPD];
    lp_s = r.sync2[SY_LP];
    lp_rise = lp_s & ~r.lp_d;

    // ----------------------------------------------------------------
    // Latency down-counters; a slot fires as it leaves one.
    // ----------------------------------------------------------------
    for (int i = 0; i < D_NUM; i++) begin
      fire[i] = (r.dly[i] == DLY_W'(1));
      if (r.dly[i] != '0) begin
        n.dly[i] = r.dly[i] - 1'b1;
      end
    end

    // ----------------------------------------------------------------
    // Transmit side: enable sampled on the link clock rising edge
    // ----------------------------------------------------------------
    bif.wvalid = 1'b0;
    bif.wdata = r.sync2[SY_TXD +: NIB_W];
    if (mclk_rise) begin
      if (tx_en_s & ~r.tx_act) begin
        n.tx_act = 1'b1;
        n.dly[D_TXCRS_ON] = TX_CRS_ON_CYC;
        n.dly[D_TXCRS_OFF] = '0;
      end else if (~tx_en_s & r.tx_act) begin
        n.tx_act = 1'b0;
        n.dly[D_TXCRS_OFF] = TX_CRS_OFF_CYC;
        n.dly[D_TXCRS_ON] = '0;
      end
      bif.wvalid = tx_en_s & ~spd10_s;
    end
    if (fire[D_TXCRS_ON]) begin
      n.crs_tx = 1'b1;
    end
    if (fire[D_TXCRS_OFF]) begin
      n.crs_tx = 1'b0;
    end

    // Buffered nibbles go out one cycle after the store presents them.
    bif.rready = line_tx_rdy;
    n.ltx_vld = bif.rvalid & line_tx_rdy;
    n.ltx_nib = bif.rdata;
    n.stall = ~bif.wready;

    // ----------------------------------------------------------------
    // Receive side: J and T strobes from the symbol decoder
    // ----------------------------------------------------------------
    if (line_rx_j & ~spd10_s) begin
      n.dly[D_RXCRS_ON] = RX_CRS_ON_CYC;
      if (r.tx_act) begin
        n.dly[D_COL_ON] = COL_ON_CYC;
      end
    end
    if (line_rx_t & ~spd10_s) begin
      n.dly[D_RXCRS_OFF] = RX_CRS_OFF_CYC;
      if (r.col | (r.dly[D_COL_ON] != '0)) begin
        n.dly[D_COL_OFF] = COL_OFF_CYC;
      end
    end
    if (fire[D_RXCRS_ON]) begin
      n.crs_rx = 1'b1;
      n.dly[D_RXDV] = RX_DV_CYC;
    end
    if (fire[D_RXDV]) begin
      n.rx_dv = 1'b1;
    end
    if (fire[D_RXCRS_OFF]) begin
      n.crs_rx = 1'b0;
      n.rx_dv = 1'b0;
      n.dly[D_RXDV] = '0;
    end
    if (fire[D_COL_ON]) begin
      n.col = 1'b1;
    end
    if (fire[D_COL_OFF]) begin
      n.col = 1'b0;
    end
    if (line_rx_vld) begin
      n.rxd = line_rx_nib;
    end
    n.crs = n.crs_rx | n.crs_tx;

    // ----------------------------------------------------------------
    // 10 Mb/s link integrity
    // ----------------------------------------------------------------
    if (r.since != {TMR_W{1'b1}}) begin
      n.since = r.since + 1'b1;
    end
    if (~spd10_s) begin
      n.since = '0;
      n.lstate = LNK_DOWN;
    end else begin
      case (r.lstate)
        LNK_DOWN: begin
          if (lp_rise & (r.since >= TMR_W'(LINK_MIN_RX_CYC))) begin
            n.since = '0;
            n.lstate = LNK_UP;
          end
        end
        LNK_UP: begin
          if (lp_rise & (r.since >= TMR_W'(LINK_MIN_RX_CYC))) begin
            n.since = '0;
          end else if (line_rx_vld) begin
            n.since = '0;
          end else if (r.since >= TMR_W'(LINK_LOSS_CYC)) begin
            n.lstate = LNK_DOWN;
          end
        end
        default: begin
          n.lstate = LNK_DOWN;
        end
      endcase
    end

    // The link state is decoded into its own flip-flop for the output.
    n.link_up = (n.lstate == LNK_UP);

    // Idle link pulse generator.
    if (r.lpw != '0) begin
      n.lpw = r.lpw - 1'b1;
    end
    if (spd10_s & ~r.tx_act) begin
      if (r.tlt >= TMR_W'(LINK_TX_PERIOD_CYC - 1)) begin
        n.tlt = '0;
        n.lpw = LINK_PW_CYC;
      end else begin
        n.tlt = r.tlt + 1'b1;
      end
    end else begin
      n.tlt = '0;
    end
    n.lp_out = (n.lpw != '0);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      r <= '0;
      r.lstate <= LNK_DOWN;
    end else begin
      r <= n;
    end
  end

endmodule
`default_nettype wire

/* File: shared/nib_buf_if.sv */
`default_nettype none
interface nib_buf_if;
  import phy_pkg::*;
  logic [NIB_W-1:0] wdata;
  logic wvalid;
  logic wready;
  logic [NIB_W-1:0] rdata;
  logic rvalid;
  logic rready;

  modport user (output wdata, output wvalid, input wready, input rdata, input rvalid, output rready);
  modport store (input wdata, input wvalid, output wready, output rdata, output rvalid, input rready);
endinterface
`default_nettype wire

/* File: shared/phy_pkg.sv */
`default_nettype none
package phy_pkg;

  // ----------------------------------------------------------------
  // Clock and bit period
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int BIT_PERIOD_NS = 10;
  localparam int NIB_W = 4;
  localparam int DLY_W = 4;
  localparam int TMR_W = 22;

  // ----------------------------------------------------------------
  // Latencies in bit periods, least and longest
  // ----------------------------------------------------------------
  localparam int RX_CRS_ON_MIN_BT = 12;
  localparam int RX_CRS_ON_MAX_BT = 16;
  localparam int RX_DV_MIN_BT = 3;
  localparam int RX_DV_MAX_BT = 5;
  localparam int RX_CRS_OFF_MIN_BT = 10;
  localparam int RX_CRS_OFF_MAX_BT = 17;
  localparam int COL_ON_MIN_BT = 16;
  localparam int COL_ON_MAX_BT = 22;
  localparam int COL_OFF_MIN_BT = 17;
  localparam int COL_OFF_MAX_BT = 20;
  localparam int TX_CRS_ON_MIN_BT = 20;
  localparam int TX_CRS_ON_MAX_BT = 24;
  localparam int TX_CRS_OFF_MIN_BT = 24;
  localparam int TX_CRS_OFF_MAX_BT = 28;
  // Transmit latency in tenths of a bit period.
  localparam int TX_LAT_MIN_BT10 = 53;
  localparam int TX_LAT_MAX_BT10 = 57;

  // Least times round up to whole cycles, never below one.
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // Longest times round down, never below one.
  function automatic int cyc_dn(input int ns);
    int c;
    c = ns / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam logic [DLY_W-1:0] RX_CRS_ON_CYC = DLY_W'(cyc_up(RX_CRS_ON_MIN_BT * BIT_PERIOD_NS));
  localparam logic [DLY_W-1:0] RX_DV_CYC = DLY_W'(cyc_up(RX_DV_MIN_BT * BIT_PERIOD_NS));
  localparam logic [DLY_W-1:0] RX_CRS_OFF_CYC = DLY_W'(cyc_up(RX_CRS_OFF_MIN_BT * BIT_PERIOD_NS));
  localparam logic [DLY_W-1:0] COL_ON_CYC = DLY_W'(cyc_up(COL_ON_MIN_BT * BIT_PERIOD_NS));
  localparam logic [DLY_W-1:0] COL_OFF_CYC = DLY_W'(cyc_up(COL_OFF_MIN_BT * BIT_PERIOD_NS));
  localparam logic [DLY_W-1:0] TX_CRS_ON_CYC = DLY_W'(cyc_up(TX_CRS_ON_MIN_BT * BIT_PERIOD_NS));
  localparam logic [DLY_W-1:0] TX_CRS_OFF_CYC = DLY_W'(cyc_up(TX_CRS_OFF_MIN_BT * BIT_PERIOD_NS));
  // The window is narrower than one clock, so the longest bound governs.
  localparam int TX_LAT_CYC = cyc_dn(TX_LAT_MAX_BT10 * BIT_PERIOD_NS / 10);

  // ----------------------------------------------------------------
  // Delay slot indices
  // ----------------------------------------------------------------
  localparam int D_RXCRS_ON = 0;
  localparam int D_RXDV = 1;
  localparam int D_RXCRS_OFF = 2;
  localparam int D_COL_ON = 3;
  localparam int D_COL_OFF = 4;
  localparam int D_TXCRS_ON = 5;
  localparam int D_TXCRS_OFF = 6;
  localparam int D_NUM = 7;

  // ----------------------------------------------------------------
  // Link integrity timing
  // ----------------------------------------------------------------
  localparam int NS_PER_MS = 1000000;
  localparam int LINK_LOSS_MS = 50;
  localparam int LINK_MIN_RX_MS = 2;
  localparam int LINK_TX_PERIOD_MS = 8;
  localparam int LINK_PW_MIN_NS = 60;
  localparam int LINK_PW_MAX_NS = 150;
  localparam int LINK_LOSS_CYC_DFLT = LINK_LOSS_MS * (NS_PER_MS / CLK_PERIOD_NS);
  localparam int LINK_MIN_RX_CYC_DFLT = LINK_MIN_RX_MS * (NS_PER_MS / CLK_PERIOD_NS);
  localparam int LINK_TX_PERIOD_CYC_DFLT = LINK_TX_PERIOD_MS * (NS_PER_MS / CLK_PERIOD_NS);
  localparam logic [DLY_W-1:0] LINK_PW_CYC = DLY_W'(cyc_up(LINK_PW_MIN_NS));

  // ----------------------------------------------------------------
  // Input synchroniser bit positions
  // ----------------------------------------------------------------
  localparam int SY_MCLK = 0;
  localparam int SY_TXD = 1;
  localparam int SY_TXEN = 5;
  localparam int SY_LP = 6;
  localparam int SY_SPD = 7;
  localparam int SY_W = 8;

  localparam int BUF_DEPTH = 2;
  localparam int BUF_CNT_W = 2;

  typedef enum logic [1:0] {
    LNK_DOWN = 2'b01,
    LNK_UP = 2'b10
  } link_state_t;

endpackage
`default_nettype wire

/* File: tb/mac_model.sv */
`default_nettype none
module mac_model (
  output var logic mii_clk,
  output var logic tx_en,
  output var logic [phy_pkg::NIB_W-1:0] txd
);
  timeunit 1ns;
  timeprecision 1ps;
  import phy_pkg::*;
  initial begin
    mii_clk = 1'b0;
    tx_en = 1'b0;
    txd = '0;
  end
  task automatic tick();
    #200 mii_clk <= 1'b1;
    #200 mii_clk <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // One frame; the transfer clock runs only in and just after it
  // ----------------------------------------------------------------
  task automatic send(input int cnt, input logic [NIB_W-1:0] base);
    #37;
    for (int i = 0; i < cnt; i++) begin
      tx_en <= 1'b1;
      txd <= base + NIB_W'(i);
      tick();
    end
    tx_en <= 1'b0;
    txd <= ~txd;
    repeat (6) tick();
  endtask
endmodule
`default_nettype wire

/* File: tb/phy_mii_timing_sva.sv */
`default_nettype none
module phy_mii_timing_sva #(
  parameter int LINK_LOSS_CYC = 400,
  parameter int LINK_TX_PERIOD_CYC = 100
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic tx_en,
  input wire logic speed_10,
  input wire logic link_pulse_in,
  input wire logic line_rx_j,
  input wire logic line_rx_t,
  input wire logic line_rx_vld,
  input wire logic line_tx_rdy,
  input wire logic crs,
  input wire logic col,
  input wire logic rx_dv,
  input wire logic line_output_pair_vld,
  input wire logic link_up,
  input wire logic link_pulse_out
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [31:0] quiet_r;
  logic [31:0] gap_r;
  logic seen_r;
  // ----------------------------------------------------------------
  // Idle time since line activity and spacing of sent link pulses
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst || !speed_10 || link_pulse_in || line_rx_vld) begin
      quiet_r <= '0;
    end else begin
      quiet_r <= quiet_r + 1;
    end
    if (rst || !speed_10) begin
      seen_r <= 1'b0;
    end else if (link_pulse_out) begin
      seen_r <= 1'b1;
    end
    if (rst || link_pulse_out) begin
      gap_r <= '0;
    end else begin
      gap_r <= gap_r + 1;
    end
  end
  sequence rx_j;
    line_rx_j && !speed_10;
  endsequence
  sequence rx_t;
    line_rx_t && !speed_10;
  endsequence
  sequence tx_go;
    $rose(tx_en) && line_tx_rdy && !speed_10;
  endsequence
  a_rx_crs_on: assert property (rx_j |-> ##[3:4] crs) else $error("crs late after J");
  a_rx_dv_on: assert property (rx_j |-> ##[4:5] rx_dv) else $error("rx_dv late after J");
  a_rx_dv_off: assert property (rx_t |-> ##[2:4] !rx_dv) else $error("rx_dv stuck after T");
  a_col_on: assert property (rx_j ##0 (tx_en && crs) |-> ##[4:6] col) else $error("col late");
  a_col_off: assert property (rx_t ##0 col |-> col[*4] ##[1:3] !col) else $error("col off window");
  a_col_none: assert property (line_rx_j && !tx_en && !crs |-> !col[*6]) else $error("false col");
  a_tx_crs_on: assert property (tx_go |-> ##[6:18] crs) else $error("tx crs late");
  a_tx_crs_off: assert property ($fell(tx_en) && !speed_10 |-> crs[*6] ##[1:12] !crs) else $error("tx crs off");
  a_tx_first_out: assert property (tx_go |-> ##[4:14] line_output_pair_vld) else $error("tx latency");
  a_link_loss: assert property (link_up |-> quiet_r < LINK_LOSS_CYC + 8) else $error("link kept too long");
  a_pulse_width: assert property ($rose(link_pulse_out) |-> link_pulse_out[*2] ##1 !link_pulse_out)
    else $error("link pulse width");
  a_pulse_period: assert property ($rose(link_pulse_out) && seen_r |->
    gap_r >= LINK_TX_PERIOD_CYC - 4 && gap_r <= LINK_TX_PERIOD_CYC + 1) else $error("link pulse period");
endmodule
bind phy_mii_timing phy_mii_timing_sva #(.LINK_LOSS_CYC(LINK_LOSS_CYC), .LINK_TX_PERIOD_CYC(LINK_TX_PERIOD_CYC)) sva_u (
  .clk_sys, .rst, .tx_en, .speed_10, .link_pulse_in, .line_rx_j, .line_rx_t, .line_rx_vld, .line_tx_rdy,
  .crs, .col, .rx_dv, .line_output_pair_vld, .link_up, .link_pulse_out);
`default_nettype wire

/* File: tb/test_phy_mii_timing.sv */
`default_nettype none
module test_phy_mii_timing;
  timeunit 1ns;
  timeprecision 1ps;
  import phy_pkg::*;
  localparam int LOSS = 400;
  localparam int MIN_RX = 20;
  localparam int PER = 100;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic speed_10 = 1'b0;
  logic link_pulse_in = 1'b0;
  logic line_rx_j = 1'b0;
  logic line_rx_t = 1'b0;
  logic line_rx_vld = 1'b0;
  logic line_tx_rdy = 1'b1;
  logic [NIB_W-1:0] line_rx_nib = '0;
  logic [NIB_W-1:0] txd, rxd, line_output_pair;
  logic mii_clk, tx_en, crs, col, rx_dv, line_output_pair_vld, tx_stall, link_up, link_pulse_out;
  logic [NIB_W-1:0] outq[$];
  int fails = 0;
  int cmp_count = 0;
  int n;
  always #25 clk_sys = ~clk_sys;
  mac_model mac_u (.mii_clk, .tx_en, .txd);
  phy_mii_timing #(.LINK_LOSS_CYC(LOSS), .LINK_MIN_RX_CYC(MIN_RX), .LINK_TX_PERIOD_CYC(PER)) dut_u (
    .clk_sys, .rst, .mii_clk, .tx_en, .txd, .speed_10, .link_pulse_in, .line_rx_j, .line_rx_t, .line_rx_vld,
    .line_rx_nib, .line_tx_rdy, .crs, .col, .rx_dv, .rxd, .line_output_pair_vld, .line_output_pair, .tx_stall,
    .link_up, .link_pulse_out);
  always @(posedge clk_sys) if (line_output_pair_vld === 1'b1) outq.push_back(line_output_pair);
  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      fails++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic pulse(input logic [2:0] w);
    @(posedge clk_sys);
    {link_pulse_in, line_rx_t, line_rx_j} <= w;
    @(posedge clk_sys);
    {link_pulse_in, line_rx_t, line_rx_j} <= 3'h0;
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return crs;
      1: return rx_dv;
      2: return col;
      3: return link_up;
      default: return link_pulse_out;
    endcase
  endfunction
  task automatic wt(input int s, input logic v);
    n = 0;
    while (pick(s) !== v && n < 600) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
  endtask
  task automatic t_rx();
    @(posedge clk_sys);
    line_rx_vld <= 1'b1;
    line_rx_nib <= 4'h5;
    pulse(3'h1);
    wt(0, 1'b1);
    chk(n >= 3 && n <= 4, "rx crs delay");
    wt(1, 1'b1);
    chk(n == 1 && rxd === 4'h5, "rx_dv delay or data");
    pulse(3'h2);
    wt(1, 1'b0);
    chk(n >= 2 && n <= 3 && crs === 1'b0 && col === 1'b0, "rx end");
    @(posedge clk_sys);
    line_rx_vld <= 1'b0;
    $display("test rx done");
  endtask
  task automatic t_tx();
    outq.delete();
    fork
      mac_u.send(6, 4'h3);
      begin
        wt(0, 1'b1);
        chk(n >= 10 && n <= 12, "tx crs delay");
      end
    join
    cyc(4);
    chk(crs === 1'b0 && outq.size() == 6, "tx end");
    foreach (outq[i]) chk(outq[i] === NIB_W'(4'h3 + i), "tx nibble order");
    $display("test tx done");
  endtask
  task automatic t_stall();
    @(posedge clk_sys);
    line_tx_rdy <= 1'b0;
    outq.delete();
    mac_u.send(4, 4'hA);
    chk(tx_stall === 1'b1 && outq.size() == 0, "buffer not full");
    @(posedge clk_sys);
    line_tx_rdy <= 1'b1;
    cyc(8);
    chk(outq.size() == 2 && outq[0] === 4'hA && outq[1] === 4'hB && tx_stall === 1'b0, "buffer drain");
    $display("test stall done");
  endtask
  task automatic t_col();
    fork
      mac_u.send(12, 4'h0);
      begin
        wt(0, 1'b1);
        pulse(3'h1);
        wt(2, 1'b1);
        chk(n >= 4 && n <= 5, "col on delay");
        pulse(3'h2);
        wt(2, 1'b0);
        chk(n >= 4 && n <= 5, "col off delay");
      end
    join
    $display("test col done");
  endtask
  task automatic t_link();
    @(posedge clk_sys);
    speed_10 <= 1'b1;
    pulse(3'h4);
    cyc(6);
    chk(link_up === 1'b0, "early pulse taken");
    pulse(3'h1);
    cyc(6);
    chk(crs === 1'b0, "J seen at 10M");
    cyc(MIN_RX);
    pulse(3'h4);
    wt(3, 1'b1);
    chk(n <= 5, "link not up");
    wt(3, 1'b0);
    chk(n >= LOSS - 10 && n <= LOSS + 10, "link loss time");
    wt(4, 1'b1);
    chk(n <= PER + 2, "no link pulse");
    wt(4, 1'b0);
    chk(n == 2, "link pulse width");
    @(posedge clk_sys);
    speed_10 <= 1'b0;
    $display("test link done");
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    cyc(2);
    chk({crs, col, rx_dv, line_output_pair_vld, tx_stall, link_up, link_pulse_out} === 7'h00, "reset state");
    t_rx();
    t_tx();
    t_stall();
    t_col();
    t_link();
    results();
  end
  // The tests need under 1000 cycles; this allows 8000, over eight times that.
  initial begin
    #400000;
    fails++;
    results();
  end
endmodule
`default_nettype wire
